// >>> src/oscsw_pkg.sv
package oscsw_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OSCSW_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] OSCSW_ADDR_STATUS = 4'h4;
  localparam logic [3:0] OSCSW_ADDR_UNLOCK = 4'h8;

  // oscillator control field positions
  localparam int OSCSW_CUR_LSB = 12;
  localparam int OSCSW_REQ_LSB = 8;
  localparam int OSCSW_FREEZE_BIT = 7;
  localparam int OSCSW_PLL_LOCK_BIT = 5;
  localparam int OSCSW_FAIL_BIT = 3;
  localparam int OSCSW_SEC_EN_BIT = 1;
  localparam int OSCSW_REQ_BIT = 0;

  // configuration word field positions
  localparam int OSCSW_CFG_SWMON_HI = 7;
  localparam int OSCSW_CFG_SWMON_LO = 6;
  localparam int OSCSW_CFG_INIT_LSB = 8;
  localparam int OSCSW_CFG_SUBMODE_LSB = 0;
  localparam int OSCSW_CFG_PINFUNC_BIT = 2;

  // unlock keys, upper byte then lower byte
  localparam logic [7:0] OSCSW_KEY_HI_A = 8'h78;
  localparam logic [7:0] OSCSW_KEY_HI_B = 8'h9a;
  localparam logic [7:0] OSCSW_KEY_LO_A = 8'h46;
  localparam logic [7:0] OSCSW_KEY_LO_B = 8'h57;

  // erased configuration values
  localparam logic [2:0] OSCSW_ERASED_SOURCE = 3'h7;
  localparam logic [1:0] OSCSW_SUBMODE_INTERNAL = 2'h3;

  // settle cycles of the new clock before switching
  localparam int OSCSW_SETTLE_CYCLES = 10;
  localparam int OSCSW_TUNE_W = 6;

  // ----------------------------------------------------------------
  // clock sources and submodes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSCSW_SRC_FAST_RC = 3'h0,
    OSCSW_SRC_FAST_RC_MULT = 3'h1,
    OSCSW_SRC_PRIMARY = 3'h2,
    OSCSW_SRC_PRIMARY_MULT = 3'h3,
    OSCSW_SRC_SECONDARY = 3'h4,
    OSCSW_SRC_LOW_POWER_RC = 3'h5,
    OSCSW_SRC_RESERVED = 3'h6,
    OSCSW_SRC_FAST_RC_DIV = 3'h7
  } oscsw_src_type;

  typedef enum logic [1:0] {
    OSCSW_SUB_EXTERNAL = 2'h0,
    OSCSW_SUB_STD_CRYSTAL = 2'h1,
    OSCSW_SUB_HS_CRYSTAL = 2'h2,
    OSCSW_SUB_INTERNAL = 2'h3
  } oscsw_sub_type;

  // analog oscillator status, grouped
  typedef struct packed {
    logic new_src_ready;
    logic pll_locked;
    logic new_clk_tick;
    logic clock_failure;
  } oscsw_osc_stat_type;

  // oscillator steering outputs, grouped
  typedef struct packed {
    oscsw_src_type active_source;
    oscsw_src_type target_source;
    logic target_enable;
    oscsw_sub_type primary_submode;
    logic second_pin_clock_out;
    logic secondary_osc_run;
    logic monitor_enable;
    logic [OSCSW_TUNE_W-1:0] fast_rc_tune;
  } oscsw_osc_ctl_type;

endpackage

// >>> src/oscsw_top.sv
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - two-bit switch/monitor config field at word bits 7:6 decides switching and monitor
// - software switching allowed only when upper config bit is zero
// - fail-safe monitor enabled only when both config bits are zero
// - power-on source taken from three-bit initial source field
// - primary submode from two-bit field; internal and secondary use 11
// - erased device starts on fast RC with postscaler, 111 and 11
// - second oscillator pin function follows separate config bit for internal modes
// - current source read-only at bits 14:12, same encoding
// - requested source writable at bits 10:8; both reset from initial source
// - bit 7 settable-only freeze; blocks switching while monitor enabled
// - bit 5 high when PLL locked, low when unlocked or disabled
// - PLL status cleared on valid switch start and non-PLL mode
// - bit 3 set by clock failure, software may only clear it
// - bit 1 runs the secondary oscillator, resets to zero
// - software sets bit 0 to switch; device clears it when done
// - unimplemented bits 15, 11, 6, 4, 2 read as zero
// - fast RC tune code steps frequency over about twelve percent
// - redundant request to current source aborts and clears request bit
// - after ready and lock wait ten new-clock cycles, then copy source
// - switching disabled holds request at zero, requested field ignored
module oscsw_top #(
  parameter int SETTLE_CYCLES = oscsw_pkg::OSCSW_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [15:0] config_word,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire oscsw_pkg::oscsw_osc_stat_type osc_stat,
  output oscsw_pkg::oscsw_osc_ctl_type osc_ctl
);
  import oscsw_pkg::*;
  initial begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin
      $error("oscsw_top: SETTLE_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {OSCSW_ST_IDLE, OSCSW_ST_WAIT_READY,
    OSCSW_ST_SETTLE} oscsw_state_type;

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  // config word caught once after reset release, through a synchroniser
  logic [15:0] cfg_s1_reg, cfg_s2_reg, cfg_s3_reg, cfg_reg;
  logic [15:0] cfg_s1_next, cfg_s2_next, cfg_s3_next, cfg_next;
  logic cfg_valid_reg, cfg_valid_next;
  logic switch_permit, monitor_on;
  oscsw_src_type init_source;
  oscsw_sub_type submode;

  assign switch_permit = cfg_valid_reg && !cfg_reg[OSCSW_CFG_SWMON_HI];
  assign monitor_on = switch_permit && !cfg_reg[OSCSW_CFG_SWMON_LO];
  assign init_source = oscsw_src_type'(cfg_reg[OSCSW_CFG_INIT_LSB +: 3]);
  assign submode = oscsw_sub_type'(cfg_reg[OSCSW_CFG_SUBMODE_LSB +: 2]);

  always_comb begin
    cfg_s1_next = config_word;
    cfg_s2_next = cfg_s1_reg;
    cfg_s3_next = cfg_s2_reg;
    cfg_next = cfg_reg;
    cfg_valid_next = cfg_valid_reg;
    // take the word once the last two stages agree
    if (!cfg_valid_reg && cfg_s2_reg == cfg_s3_reg) begin
      cfg_next = cfg_s3_reg;
      cfg_valid_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_s1_reg <= '1;
      cfg_s2_reg <= '0;
      cfg_s3_reg <= '1; // differs from stage two, so no capture before the word arrives
      cfg_reg <= '1; // erased: fast RC divided, internal submode
      cfg_valid_reg <= 1'b0;
    end else if (clk_en) begin
      cfg_s1_reg <= cfg_s1_next;
      cfg_s2_reg <= cfg_s2_next;
      cfg_s3_reg <= cfg_s3_next;
      cfg_reg <= cfg_next;
      cfg_valid_reg <= cfg_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // status input synchroniser
  // ----------------------------------------------------------------
  logic [3:0] st_s1_reg, st_s2_reg, st_s3_reg, st_reg;
  logic [3:0] st_s1_next, st_s2_next, st_s3_next, st_next;
  oscsw_osc_stat_type st;

  always_comb begin
    st_s1_next = osc_stat;
    st_s2_next = st_s1_reg;
    st_s3_next = st_s2_reg;
    st_next = st_reg;
    // a bit changes only when stages two and three agree
    for (int i = 0; i < 4; i++) begin
      if (st_s2_reg[i] == st_s3_reg[i]) begin
        st_next[i] = st_s3_reg[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_s1_reg <= '0;
      st_s2_reg <= '0;
      st_s3_reg <= '0;
      st_reg <= '0;
    end else if (clk_en) begin
      st_s1_reg <= st_s1_next;
      st_s2_reg <= st_s2_next;
      st_s3_reg <= st_s3_next;
      st_reg <= st_next;
    end
  end

  assign st = oscsw_osc_stat_type'(st_reg);

  // ----------------------------------------------------------------
  // registers, unlock and switch sequencer
  // ----------------------------------------------------------------
  logic [1:0] key_hi_reg, key_hi_next, key_lo_reg, key_lo_next;
  oscsw_src_type cur_reg, cur_next, req_reg, req_next;
  logic freeze_reg, freeze_next, lock_reg, lock_next, fail_reg, fail_next;
  logic sec_en_reg, sec_en_next, swreq_reg, swreq_next;
  logic [OSCSW_TUNE_W-1:0] tune_reg, tune_next;
  logic [7:0] settle_reg, settle_next;
  logic tick_d_reg, tick_d_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic src_loaded_reg, src_loaded_next;
  oscsw_state_type state_reg, state_next;
  logic bus_req, wr, tick_edge, uses_pll;
  logic [15:0] ctl_word;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = bus_req && wb_we_i;
  assign tick_edge = st.new_clk_tick && !tick_d_reg;
  assign uses_pll = (cur_reg == OSCSW_SRC_PRIMARY_MULT) || (cur_reg == OSCSW_SRC_FAST_RC_MULT);
  // readback word, unimplemented bits zero
  always_comb begin
    ctl_word = '0;
    ctl_word[OSCSW_CUR_LSB +: 3] = cur_reg;
    ctl_word[OSCSW_REQ_LSB +: 3] = req_reg;
    ctl_word[OSCSW_FREEZE_BIT] = freeze_reg;
    ctl_word[OSCSW_PLL_LOCK_BIT] = lock_reg;
    ctl_word[OSCSW_FAIL_BIT] = fail_reg;
    ctl_word[OSCSW_SEC_EN_BIT] = sec_en_reg;
    ctl_word[OSCSW_REQ_BIT] = swreq_reg;
  end

  always_comb begin
    key_hi_next = key_hi_reg;
    key_lo_next = key_lo_reg;
    cur_next = cur_reg;
    req_next = req_reg;
    freeze_next = freeze_reg;
    lock_next = lock_reg;
    fail_next = fail_reg;
    sec_en_next = sec_en_reg;
    swreq_next = swreq_reg;
    tune_next = tune_reg;
    settle_next = settle_reg;
    state_next = state_reg;
    src_loaded_next = src_loaded_reg;
    tick_d_next = st.new_clk_tick;
    ack_next = bus_req;
    rdata_next = rdata_reg;
    // sources load from configuration once it is captured
    if (cfg_valid_reg && !src_loaded_reg) begin
      cur_next = init_source;
      req_next = init_source;
      src_loaded_next = 1'b1;
    end
    // reads
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OSCSW_ADDR_CONTROL: rdata_next = {16'h0000, ctl_word};
        OSCSW_ADDR_STATUS: rdata_next = {24'h000000, 2'h0, tune_reg};
        OSCSW_ADDR_UNLOCK: rdata_next = {28'h0000000, key_hi_reg, key_lo_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    // writes; keys arm a byte only for the very next byte write
    if (wr && wb_adr_i == OSCSW_ADDR_CONTROL && wb_sel_i[1]) begin
      key_hi_next = 2'h0;
      if (key_hi_reg == 2'h2) begin
        if (!(monitor_on && freeze_reg)) begin
          req_next = oscsw_src_type'(wb_dat_i[OSCSW_REQ_LSB +: 3]);
        end
      end else if (key_hi_reg == 2'h1 && wb_dat_i[15:8] == OSCSW_KEY_HI_B) begin
        key_hi_next = 2'h2;
      end else if (wb_dat_i[15:8] == OSCSW_KEY_HI_A) begin
        key_hi_next = 2'h1;
      end
    end
    if (wr && wb_adr_i == OSCSW_ADDR_CONTROL && wb_sel_i[0]) begin
      key_lo_next = 2'h0;
      if (key_lo_reg == 2'h2) begin
        if (wb_dat_i[OSCSW_FREEZE_BIT]) begin
          freeze_next = 1'b1; // settable only
        end
        if (!wb_dat_i[OSCSW_FAIL_BIT]) begin
          fail_next = 1'b0; // clearable only
        end
        sec_en_next = wb_dat_i[OSCSW_SEC_EN_BIT];
        if (wb_dat_i[OSCSW_REQ_BIT] && switch_permit && !(monitor_on && freeze_reg)) begin
          swreq_next = 1'b1;
        end
      end else if (key_lo_reg == 2'h1 && wb_dat_i[7:0] == OSCSW_KEY_LO_B) begin
        key_lo_next = 2'h2;
      end else if (wb_dat_i[7:0] == OSCSW_KEY_LO_A) begin
        key_lo_next = 2'h1;
      end
    end
    if (wr && wb_adr_i == OSCSW_ADDR_STATUS && wb_sel_i[0]) begin
      tune_next = wb_dat_i[OSCSW_TUNE_W-1:0];
    end
    // switch sequencer
    case (state_reg)
      OSCSW_ST_IDLE: begin
        if (swreq_reg) begin
          if (req_reg == cur_reg) begin
            swreq_next = 1'b0; // redundant, abort
          end else begin
            lock_next = 1'b0;
            fail_next = 1'b0;
            state_next = OSCSW_ST_WAIT_READY;
          end
        end
      end
      OSCSW_ST_WAIT_READY: begin
        settle_next = 8'(SETTLE_CYCLES);
        if (st.new_src_ready && (st.pll_locked || !(req_reg == OSCSW_SRC_PRIMARY_MULT
            || req_reg == OSCSW_SRC_FAST_RC_MULT))) begin
          state_next = OSCSW_ST_SETTLE;
        end
      end
      OSCSW_ST_SETTLE: begin
        if (tick_edge) begin
          if (settle_reg == 8'h01) begin
            cur_next = req_reg;
            swreq_next = 1'b0;
            state_next = OSCSW_ST_IDLE;
          end else begin
            settle_next = settle_reg - 8'h01;
          end
        end
      end
      default: state_next = OSCSW_ST_IDLE;
    endcase
    // pll status follows lock outside a switch, low for non-pll modes
    if (state_reg == OSCSW_ST_IDLE && !(swreq_reg && req_reg != cur_reg)) begin
      lock_next = uses_pll && st.pll_locked;
    end
    if (!switch_permit) begin
      swreq_next = 1'b0;
      state_next = OSCSW_ST_IDLE;
    end
    // hardware set wins over software clear
    if (monitor_on && st.clock_failure) begin
      fail_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_hi_reg <= 2'h0;
      key_lo_reg <= 2'h0;
      cur_reg <= OSCSW_SRC_FAST_RC_DIV;
      req_reg <= OSCSW_SRC_FAST_RC_DIV;
      freeze_reg <= 1'b0;
      lock_reg <= 1'b0;
      fail_reg <= 1'b0;
      sec_en_reg <= 1'b0;
      swreq_reg <= 1'b0;
      tune_reg <= '0;
      settle_reg <= 8'h00;
      tick_d_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      src_loaded_reg <= 1'b0;
      state_reg <= OSCSW_ST_IDLE;
    end else if (clk_en) begin
      key_hi_reg <= key_hi_next;
      key_lo_reg <= key_lo_next;
      cur_reg <= cur_next;
      req_reg <= req_next;
      freeze_reg <= freeze_next;
      lock_reg <= lock_next;
      fail_reg <= fail_next;
      sec_en_reg <= sec_en_next;
      swreq_reg <= swreq_next;
      tune_reg <= tune_next;
      settle_reg <= settle_next;
      tick_d_reg <= tick_d_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      src_loaded_reg <= src_loaded_next;
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_comb begin
    osc_ctl.active_source = cur_reg;
    // requested field steers nothing unless switching is permitted
    osc_ctl.target_source = switch_permit ? req_reg : cur_reg;
    osc_ctl.target_enable = (state_reg != OSCSW_ST_IDLE);
    osc_ctl.primary_submode = (cur_reg == OSCSW_SRC_PRIMARY || cur_reg == OSCSW_SRC_PRIMARY_MULT)
        ? submode : OSCSW_SUB_INTERNAL;
    osc_ctl.second_pin_clock_out = (osc_ctl.primary_submode == OSCSW_SUB_INTERNAL)
        && cfg_reg[OSCSW_CFG_PINFUNC_BIT];
    osc_ctl.secondary_osc_run = sec_en_reg || cur_reg == OSCSW_SRC_SECONDARY;
    osc_ctl.monitor_enable = monitor_on;
    osc_ctl.fast_rc_tune = tune_reg;
  end

endmodule

// >>> dv/oscsw_properties.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker for the clock switch block
// ----------------------------------------------------------------
module oscsw_properties import oscsw_pkg::*; #(
  parameter int SETTLE_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [15:0] config_word,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire oscsw_pkg::oscsw_osc_ctl_type osc_ctl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // a fresh request, and a completed control read
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence ctl_rd_s;
    wb_ack_o && !wb_we_i && wb_adr_i == OSCSW_ADDR_CONTROL;
  endsequence

  ack_next_a: assert property (taken_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unimpl_zero_a: assert property (ctl_rd_s |-> (wb_dat_o[15:0] & 16'h8854) == 16'h0)
    else $error("unimplemented control bit reads one");
  no_switch_a: assert property (ctl_rd_s ##0 config_word[7] |->
    !wb_dat_o[0] && wb_dat_o[14:12] == config_word[10:8])
    else $error("switch active while switching disabled");
  monitor_cfg_a: assert property (wb_ack_o |->
    osc_ctl.monitor_enable == (config_word[7:6] == 2'h0))
    else $error("monitor enable disagrees with config");
  submode_a: assert property (wb_ack_o |-> osc_ctl.primary_submode ==
    (osc_ctl.active_source inside {OSCSW_SRC_PRIMARY, OSCSW_SRC_PRIMARY_MULT}
    ? config_word[1:0] : OSCSW_SUBMODE_INTERNAL))
    else $error("primary submode disagrees with config");
  lock_mode_a: assert property (ctl_rd_s ##0 wb_dat_o[5] |->
    wb_dat_o[14:12] inside {3'h1, 3'h3})
    else $error("lock status set in a mode without multiplier");
  fail_mon_a: assert property (ctl_rd_s ##0 wb_dat_o[3] |-> osc_ctl.monitor_enable)
    else $error("clock fail flag without monitor");
  sec_run_a: assert property (ctl_rd_s |->
    $past(osc_ctl.secondary_osc_run) == (wb_dat_o[1] || wb_dat_o[14:12] == OSCSW_SRC_SECONDARY))
    else $error("secondary enable bit and output differ");
  cur_field_a: assert property (ctl_rd_s |->
    wb_dat_o[14:12] == $past(osc_ctl.active_source))
    else $error("current source field and output differ");
endmodule

bind oscsw_top oscsw_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (.clock(clock),
  .rstn(rstn), .clk_en(clk_en), .config_word(config_word), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .osc_ctl(osc_ctl));

// >>> dv/tb_oscillator_select_and_switch_control.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: read %h, expected %h", $time, (got), (exp)); end end

module tb_oscillator_select_and_switch_control;
  import oscsw_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] config_word = 16'hffff;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  oscsw_osc_stat_type osc_stat = '0;
  oscsw_osc_ctl_type osc_ctl;
  int fails = 0;
  int num_checks = 0;

  oscsw_top #(.SETTLE_CYCLES(10)) DUT (.clock(clock), .rstn(rstn), .clk_en(clk_en),
    .config_word(config_word), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .osc_stat(osc_stat), .osc_ctl(osc_ctl));

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  // one classic wishbone cycle, ack sampled at the rising edge
  task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic w);
    @(posedge clock);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_we_i <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clock);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clock);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(a, d, s, 1'b1);
  endtask

  // read and compare the masked low half
  task automatic ck(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
    wb(a, 32'h0, 4'hf, 1'b0);
    `CHK(rd[15:0] & mask, exp)
  endtask

  // keyed upper byte write of the requested source
  task automatic hi(input logic [2:0] src);
    wr(4'h0, 32'h7800, 4'h2);
    wr(4'h0, 32'h9a00, 4'h2);
    wr(4'h0, {21'h0, src, 8'h0}, 4'h2);
  endtask

  // keyed lower byte write
  task automatic lo(input logic [7:0] v);
    wr(4'h0, 32'h46, 4'h1);
    wr(4'h0, 32'h57, 4'h1);
    wr(4'h0, {24'h0, v}, 4'h1);
  endtask

  // rising edges of the new clock, slow enough for the synchronisers
  task automatic tick(input int n);
    repeat (n) begin
      osc_stat.new_clk_tick <= 1'b1;
      repeat (6) @(posedge clock);
      osc_stat.new_clk_tick <= 1'b0;
      repeat (6) @(posedge clock);
    end
    repeat (20) @(posedge clock);
  endtask

  task automatic do_reset(input logic [15:0] cfg);
    @(posedge clock);
    config_word <= cfg;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    // erased device, switching off
    do_reset(16'hffff);
    ck(4'h0, 16'hffff, 16'h7700);
    `CHK(osc_ctl.primary_submode, OSCSW_SUB_INTERNAL)
    `CHK(osc_ctl.monitor_enable, 1'b0)
    wr(4'h0, 32'h7800, 4'h2);
    ck(4'h8, 16'hffff, 16'h0004);
    hi(3'h0);
    lo(8'h01);
    ck(4'h0, 16'h7001, 16'h7000);
    `CHK(osc_ctl.target_source, OSCSW_SRC_FAST_RC_DIV)
    wr(4'h4, 32'h3f, 4'h1);
    ck(4'h4, 16'hffff, 16'h003f);
    `CHK(osc_ctl.fast_rc_tune, 6'h3f)
    wr(4'hc, 32'hffff, 4'hf);
    ck(4'hc, 16'hffff, 16'h0000);
    // primary high-speed crystal, switching and monitor on
    do_reset(16'h0206);
    ck(4'h0, 16'hffff, 16'h2200);
    `CHK(osc_ctl.primary_submode, OSCSW_SUB_HS_CRYSTAL)
    `CHK(osc_ctl.second_pin_clock_out, 1'b0)
    `CHK(osc_ctl.monitor_enable, 1'b1)
    wr(4'h0, 32'h0500, 4'h2);
    ck(4'h0, 16'hffff, 16'h2200);
    hi(3'h0);
    lo(8'h02);
    ck(4'h0, 16'hffff, 16'h2002);
    `CHK(osc_ctl.secondary_osc_run, 1'b1)
    osc_stat.new_src_ready <= 1'b1;
    lo(8'h03);
    tick(9);
    ck(4'h0, 16'h7001, 16'h2001);
    `CHK(osc_ctl.target_enable, 1'b1)
    tick(1);
    ck(4'h0, 16'hffff, 16'h0002);
    `CHK(osc_ctl.active_source, OSCSW_SRC_FAST_RC)
    `CHK(osc_ctl.target_enable, 1'b0)
    `CHK(osc_ctl.second_pin_clock_out, 1'b1)
    lo(8'h03);
    tick(0);
    ck(4'h0, 16'hffff, 16'h0002);
    osc_stat.pll_locked <= 1'b1;
    hi(3'h1);
    lo(8'h03);
    tick(10);
    ck(4'h0, 16'hffff, 16'h1122);
    osc_stat.pll_locked <= 1'b0;
    tick(0);
    ck(4'h0, 16'hffff, 16'h1102);
    osc_stat.clock_failure <= 1'b1;
    repeat (10) @(posedge clock);
    osc_stat.clock_failure <= 1'b0;
    tick(0);
    ck(4'h0, 16'hffff, 16'h110a);
    lo(8'h02);
    ck(4'h0, 16'hffff, 16'h1102);
    lo(8'h0a);
    ck(4'h0, 16'hffff, 16'h1102);
    lo(8'h82);
    ck(4'h0, 16'hffff, 16'h1182);
    lo(8'h02);
    ck(4'h0, 16'hffff, 16'h1182);
    hi(3'h0);
    lo(8'h83);
    tick(10);
    ck(4'h0, 16'h7081, 16'h1080);
    // clock enable low freezes the synchronisers and the flags
    clk_en <= 1'b0;
    osc_stat.clock_failure <= 1'b1;
    repeat (10) @(posedge clock);
    osc_stat.clock_failure <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    tick(0);
    ck(4'h0, 16'h0008, 16'h0000);
    stop_test();
  end
endmodule
